// [bench/divided_pwm_generator_test.sv]
// self-checking bench for the divided pwm generator, full-range variant
// assumes ticks and codes from osc_model and a wishbone master with idle cycles between requests
`timescale 1ns/1ps
module divided_pwm_generator_test;
  typedef struct {logic [31:0] d; logic [31:0] m;} note_t;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0, pwm, tick, hold;
  logic [3:0] code_sel = 4'h2, code, old, nw;
  logic [3:0] code_tab[5] = '{4'h1, 4'h0, 4'hf, 4'he, 4'hd};
  logic [31:0] seed = 32'h0000002b, q;
  pwm_pkg::wb_req_t wb_req = '0;
  pwm_pkg::wb_rsp_t wb_rsp;
  note_t notes[$], nt;
  int n_mismatch = 0, check_count = 0, cycles = 0, ticks = 0, s, t0, lim;
  int set_tab[3] = '{0, 1023, 600};
  osc_model u_osc_model (.clk_i(clk), .slow_i(slow), .code_sel_i(code_sel), .tick_o(tick), .code_o(code));
  divided_pwm_generator u_divided_pwm_generator (.clk_i(clk), .rst_i(rst), .master_tick_i(tick),
    .code_i(code), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .pwm_o(pwm));
  initial forever #20 clk = ~clk;
  always @(posedge tick) ticks++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      print_verdict();
    end else if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
      nt = notes.pop_front();
      check(wb_rsp.dat & nt.m, nt.d & nt.m);
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("%0d mismatches in %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reads note their expected data; the watcher compares at ack
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] d, input logic [31:0] m);
    if (!we) notes.push_back('{d, m});
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h3, d};
    // only the bench timeout ends a wait for ack
    do begin
      @(posedge clk);
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask
  function automatic int hi(int st, int r);
    int d;
    d = st <= 102 ? 0 : st >= 922 ? 1024 : (5 * st - 512) / 4;
    return (d * r + 512) / 1024;
  endfunction
  function automatic int ratio(logic [3:0] c);
    return 1 << (2 * (c[2:0] ^ {3{c[3]}}));
  endfunction
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // samples pwm mid-tick over 64 ticks: high ticks and rising edges
  task automatic meas(input logic [3:0] c, input int st);
    int h, e, r, x;
    logic p;
    h = 0;
    e = 0;
    r = ratio(c);
    x = c[3] ? r - hi(st, r) : hi(st, r);
    @(posedge tick);
    repeat (12) @(posedge clk);
    p = pwm;
    repeat (64) begin
      @(posedge tick);
      repeat (12) @(posedge clk);
      h += int'(pwm === 1'b1);
      e += int'(pwm === 1'b1 && p === 1'b0);
      p = pwm;
    end
    check(32'(h), 32'(64 / r * x));
    check(32'(e), 32'(x > 0 && x < r ? 64 / r : 0));
    $display("duty test done, code %0d setting %0d", c, st);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 4'h0, 32'h3ff, 32'h0);
    hold = 1'b0;
    repeat (480) begin
      @(posedge tick);
      hold = hold | pwm;
    end
    check({31'h0, hold}, 32'h0);
    repeat (40) @(posedge tick);
    check({31'h0, pwm}, 32'h1);
    bus(1'b0, 4'h0, 32'h3ff, 32'h3ff);
    bus(1'b0, 4'h8, 32'h0, 32'hffffffff);
    bus(1'b1, 4'h4, 32'hfff, 32'h0);
    bus(1'b0, 4'h4, 32'ha44, 32'hfff);
    $display("start-up and register test done");
    for (int i = 0; i < 5; i++) begin
      s = i < 3 ? set_tab[i] : int'(xs() % 1024);
      bus(1'b1, 4'h0, 32'(s), 32'h0);
      bus(1'b0, 4'h0, 32'(s), 32'h3ff);
      repeat (32) @(posedge tick);
      meas(4'h2, s);
    end
    bus(1'b1, 4'h0, 32'd600, 32'h0);
    for (int i = 0; i < 5; i++) begin
      old = code_sel;
      nw = code_tab[i];
      if (nw == 4'hf) begin
        code_sel <= 4'h7; // a wandering code that must never be applied
        repeat (30) @(posedge tick);
      end
      code_sel <= nw;
      slow <= (i == 4);
      t0 = ticks;
      lim = 16 * ((old > nw ? old - nw : nw - old) + 6);
      do begin
        @(posedge tick);
        bus(1'b0, 4'h4, 32'h0, 32'h0);
        check(32'(q[4:1] == old || q[4:1] == nw), 32'h1);
      end while (q[4:1] != nw && ticks - t0 < 600);
      check(32'(ticks - t0 >= lim && ticks - t0 <= lim + ratio(old) + 8), 32'h1);
      meas(nw, 600);
    end
    check(32'(notes.size()), 32'h0);
    print_verdict();
  end
endmodule

// [bench/osc_model.sv]
// master oscillator and divider-select network seen by the pwm block
// assumes the bench clock; both outputs change only after its rising edges
`timescale 1ns/1ps
module osc_model (
  input wire logic clk_i, // bench clock
  input wire logic slow_i, // stretch the tick period
  input wire logic [3:0] code_sel_i, // wanted divider_select_code
  output logic tick_o, // master tick
  output logic [3:0] code_o // resolved code
);
  // 26 clocks a tick keeps the master rate under 1 MHz
  initial begin
    tick_o = 1'b0;
    forever begin
      repeat (slow_i ? 26 : 13) @(posedge clk_i);
      tick_o <= ~tick_o;
    end
  end
  always @(posedge clk_i) code_o <= code_sel_i;
endmodule

// [common/pwm_pkg.sv]
// constants, types and carriers for the divided pwm generator
// assumes one 25 MHz clock, a synchronous active-high reset and a classic wishbone master
// Overview of operation
// - one output period per divide_ratio master ticks; master tick at most 1 MHz.
// - exactly eight divide ratios, powers of four from 1 to 16384.
// - 4-bit divider_select_code; top bit is polarity_invert.
// - codes 0-7 map 1 up to 16384; codes 8-15 mirror, 16384 down to 1.
// - polarity_invert set inverts the finished waveform.
// - duty equals setting over 0.8 of reference, minus one eighth.
// - settings below 0.1 V or above 0.9 V change duty no further.
// - unclamped variant spans 0-100%, resting low at 0% and high at 100%.
// - two-sided clamp variant limits duty to 5-95%, always toggling; the code rests at ratio 1, and at ratio 4 near either clamp.
// - one-sided variants span 0-95% or 5-100%, resting only at open extreme; the code also rests at ratio 1, and at ratio 4 near the clamp.
// - clamps apply before inversion.
// - new code accepted only after 16 times (code difference plus 6) master ticks.
// - changing code ignored until stable; jumps straight to the new code.
// - new ratio and polarity take effect glitch-free at a period boundary.
// - output held low for 500 master ticks after reset while code resolves.
// - first pulse after start-up has correct width without inversion; the code applies polarity_invert from the first period.
package pwm_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int MASTER_MAX_HZ = 1000000;
  // fewest clocks between ticks at the highest master rate; nothing in the logic uses it
  localparam int MIN_CLKS_PER_TICK = CLK_HZ / MASTER_MAX_HZ;

  localparam logic [3:0] DUTY_ADR = 4'h0;
  localparam logic [3:0] STATUS_ADR = 4'h4;
  localparam logic [9:0] DUTY_RESET = 10'h000;

  localparam logic [8:0] START_TICKS = 9'h1f4;
  localparam logic [8:0] FILTER_MULT = 9'h010;
  localparam logic [8:0] FILTER_BASE = 9'h006;

  // setting: 10 bits, full scale is the reference; duty: 1/1024 units
  localparam logic [9:0] SET_LOW = 10'h066;
  localparam logic [9:0] SET_HIGH = 10'h39a;
  localparam logic [12:0] SET_OFFSET = 13'h0200;
  localparam logic [10:0] DUTY_FULL = 11'h400;
  localparam logic [10:0] DUTY_MIN_CLAMP = 11'h033;
  localparam logic [10:0] DUTY_MAX_CLAMP = 11'h3cd;
  localparam logic [24:0] ROUND_HALF = 25'h0000200;

  typedef enum logic [1:0] {
    VAR_FULL = 2'h0,
    VAR_BOTH = 2'h1,
    VAR_MAX_ONLY = 2'h2,
    VAR_MIN_ONLY = 2'h3
  } variant_t;

  typedef enum logic [1:0] {
    PH_START = 2'b01,
    PH_RUN = 2'b10
  } phase_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage

// [rtl/divided_pwm_generator.sv]
// divided pwm generator: divider, code filter, duty clamps and wishbone registers
// assumes master_tick_i and code_i are asynchronous pins, everything else on clk_i
`timescale 1ns/1ps
module divided_pwm_generator #(
  parameter pwm_pkg::variant_t VARIANT = pwm_pkg::VAR_FULL
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic master_tick_i, // master oscillator, rising edge is one tick
  input wire logic [3:0] code_i, // digitised divider_select_code
  input wire pwm_pkg::wb_req_t wb_req_i, // wishbone request
  output pwm_pkg::wb_rsp_t wb_rsp_o, // wishbone answer
  output logic pwm_o // pwm output
);

  typedef struct packed {
    logic meta_tick;
    logic sync_tick;
    logic last_tick;
    logic [3:0] meta_code;
    logic [3:0] sync_code;
    pwm_pkg::phase_t phase;
    logic [8:0] start_cnt;
    logic [3:0] cand;
    logic [8:0] timer;
    logic [3:0] active;
    logic [13:0] cnt;
    logic [14:0] high;
    logic pwm;
    logic [9:0] duty;
    logic ack;
    logic [31:0] rdat;
  } state_t;

  state_t s;
  state_t next_s;

  // power-of-four ratio for a code, mirrored about the midpoint
  function automatic logic [14:0] ratio_of(input logic [3:0] code);
    logic [2:0] idx;
    idx = code[3] ? ~code[2:0] : code[2:0];
    ratio_of = 15'h0001 << {idx, 1'b0};
  endfunction

  // clamped duty in 1/1024 units from the setting
  function automatic logic [10:0] duty_of(input logic [9:0] set);
    logic [12:0] scaled;
    logic [10:0] d;
    scaled = 13'(set) * 13'h0005;
    if (set <= pwm_pkg::SET_LOW) begin
      d = 11'h000;
    end else if (set >= pwm_pkg::SET_HIGH) begin
      d = pwm_pkg::DUTY_FULL;
    end else begin
      d = 11'((scaled - pwm_pkg::SET_OFFSET) >> 2);
    end
    if ((VARIANT == pwm_pkg::VAR_BOTH || VARIANT == pwm_pkg::VAR_MIN_ONLY) && d < pwm_pkg::DUTY_MIN_CLAMP) begin
      d = pwm_pkg::DUTY_MIN_CLAMP;
    end
    if ((VARIANT == pwm_pkg::VAR_BOTH || VARIANT == pwm_pkg::VAR_MAX_ONLY) && d > pwm_pkg::DUTY_MAX_CLAMP) begin
      d = pwm_pkg::DUTY_MAX_CLAMP;
    end
    duty_of = d;
  endfunction

  // high ticks for a period of the given ratio, rounded to nearest tick
  function automatic logic [14:0] high_of(input logic [10:0] d, input logic [14:0] ratio);
    logic [24:0] prod;
    prod = 25'(d) * 25'(ratio) + pwm_pkg::ROUND_HALF;
    high_of = prod[24:10];
  endfunction

  logic tick;
  logic [14:0] ratio;
  logic period_end;
  logic [10:0] duty_frac;
  logic raw;
  logic [3:0] diff;
  logic pending;
  logic wb_hit;

  always_comb begin
    tick = s.sync_tick & ~s.last_tick;
    ratio = ratio_of(s.active);
    period_end = tick && ({1'b0, s.cnt} == ratio - 15'h0001);
    duty_frac = duty_of(s.duty);
    // clamps are done on the raw duty; inversion only at the pin
    raw = {1'b0, s.cnt} < s.high;
    // settle time grows with the distance from the code in use, not from the last candidate
    diff = (s.sync_code > s.active) ? s.sync_code - s.active : s.active - s.sync_code;
    pending = (s.phase == pwm_pkg::PH_RUN) && s.timer == 9'h000 && s.cand != s.active;
    wb_hit = wb_req_i.cyc & wb_req_i.stb & ~s.ack;
  end

  always_comb begin
    next_s = s;
    next_s.meta_tick = master_tick_i;
    next_s.sync_tick = s.meta_tick;
    next_s.last_tick = s.sync_tick;
    next_s.meta_code = code_i;
    next_s.sync_code = s.meta_code;

    // code filter: any change restarts the settle timer
    if (tick) begin
      if (s.sync_code != s.cand) begin
        next_s.cand = s.sync_code;
        next_s.timer = 9'(pwm_pkg::FILTER_MULT * (9'(diff) + pwm_pkg::FILTER_BASE));
      end else if (s.timer != 9'h000) begin
        next_s.timer = s.timer - 9'h001;
      end
    end

    case (s.phase)
      pwm_pkg::PH_START: begin
        if (tick) begin
          if (s.start_cnt == pwm_pkg::START_TICKS - 9'h001) begin
            // first period begins cleanly with the resolved code
            next_s.phase = pwm_pkg::PH_RUN;
            next_s.active = s.sync_code;
            next_s.cand = s.sync_code;
            next_s.timer = 9'h000;
            next_s.cnt = 14'h0000;
            next_s.high = high_of(duty_frac, ratio_of(s.sync_code));
          end else begin
            next_s.start_cnt = s.start_cnt + 9'h001;
          end
        end
      end
      pwm_pkg::PH_RUN: begin
        if (period_end) begin
          // the switch waits for the period edge so no pulse is cut
          next_s.cnt = 14'h0000;
          if (pending) begin
            next_s.active = s.cand;
            next_s.high = high_of(duty_frac, ratio_of(s.cand));
          end else begin
            next_s.high = high_of(duty_frac, ratio);
          end
        end else if (tick) begin
          next_s.cnt = s.cnt + 14'h0001;
        end
      end
      default: begin
        next_s.phase = pwm_pkg::PH_START;
      end
    endcase

    // low during start-up; inverted after the duty clamps
    next_s.pwm = (s.phase == pwm_pkg::PH_RUN) & (raw ^ s.active[3]);

    next_s.ack = wb_hit;
    next_s.rdat = 32'h00000000;
    if (wb_hit) begin
      if (wb_req_i.adr == pwm_pkg::DUTY_ADR) begin
        next_s.rdat = {22'h000000, s.duty};
        if (wb_req_i.we && wb_req_i.sel[0]) begin
          next_s.duty[7:0] = wb_req_i.dat[7:0];
        end
        if (wb_req_i.we && wb_req_i.sel[1]) begin
          next_s.duty[9:8] = wb_req_i.dat[9:8];
        end
      end else if (wb_req_i.adr == pwm_pkg::STATUS_ADR) begin
        next_s.rdat = {20'h00000, s.pwm, pending, s.phase == pwm_pkg::PH_RUN, s.cand, s.active, 1'b0};
      end
    end

    if (rst_i) begin
      next_s = '0;
      next_s.phase = pwm_pkg::PH_START;
      next_s.duty = pwm_pkg::DUTY_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign pwm_o = s.pwm;
  assign wb_rsp_o.ack = s.ack;
  assign wb_rsp_o.dat = s.rdat;

  out_low_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(s.phase) == pwm_pkg::PH_START |-> !pwm_o)
    else $error("output not low during start-up");

  period_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && period_end |=> s.cnt == 14'h0000)
    else $error("period counter did not wrap at ratio");

  ratio_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(ratio) && (ratio & 15'h2aaa) == 15'h0000)
    else $error("ratio not a power of four");

  high_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && !period_end |=> $stable(s.high))
    else $error("high time changed inside a period");

  clamp_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    duty_frac <= pwm_pkg::DUTY_FULL
    && (!(VARIANT == pwm_pkg::VAR_BOTH || VARIANT == pwm_pkg::VAR_MIN_ONLY) || duty_frac >= pwm_pkg::DUTY_MIN_CLAMP)
    && (!(VARIANT == pwm_pkg::VAR_BOTH || VARIANT == pwm_pkg::VAR_MAX_ONLY) || duty_frac <= pwm_pkg::DUTY_MAX_CLAMP))
    else $error("duty clamp violated");

  code_direct_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(s.phase) == pwm_pkg::PH_RUN && $changed(s.active) |-> s.active == $past(s.cand) && $past(s.timer) == 9'h000)
    else $error("code applied before filter settled");

  switch_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(s.phase) == pwm_pkg::PH_RUN && $changed(s.active) |-> $past(period_end))
    else $error("code switched inside a period");

  rest_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && s.high == 15'h0000 && !s.active[3] ##1 s.high == 15'h0000 && !s.active[3]
    |=> !pwm_o)
    else $error("output toggled at zero duty");

  invert_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && s.active[3] && $stable(s.active) |=> pwm_o == !$past(raw))
    else $error("inverted output wrong");

  start_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_START && tick && s.start_cnt != pwm_pkg::START_TICKS - 9'h001 |=> s.start_cnt == $past(s.start_cnt) + 9'h001)
    else $error("start-up count did not advance on a tick");

  start_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_START && !tick |=> s.phase == pwm_pkg::PH_START && $stable(s.start_cnt))
    else $error("start-up count moved without a tick");

  start_leave_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_START && tick && s.start_cnt == pwm_pkg::START_TICKS - 9'h001 |=> s.phase == pwm_pkg::PH_RUN && s.cnt == 14'h0000)
    else $error("start-up did not end cleanly");

  start_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_START && tick && s.start_cnt == pwm_pkg::START_TICKS - 9'h001 |=> s.active == $past(s.sync_code) && s.cand == s.active)
    else $error("start-up code not taken from the pin");

  cnt_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && tick && !period_end |=> s.cnt == $past(s.cnt) + 14'h0001)
    else $error("period counter did not step on a tick");

  cnt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && !tick |=> $stable(s.cnt) && $stable(s.active) && $stable(s.high))
    else $error("period state moved without a tick");

  cnt_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN |-> {1'b0, s.cnt} < ratio)
    else $error("period counter beyond ratio");

  ratio_ends_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.active == 4'h0 || s.active == 4'hf |-> ratio == 15'h0001)
    else $error("end codes not at ratio one");

  ratio_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.active == 4'h1 || s.active == 4'he |-> ratio == 15'h0004)
    else $error("codes one and fourteen not at ratio four");

  ratio_sixteen_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.active == 4'h2 || s.active == 4'hd |-> ratio == 15'h0010)
    else $error("codes two and thirteen not at ratio sixteen");

  filter_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && tick && s.sync_code != s.cand
    |=> s.cand == $past(s.sync_code) && s.timer >= 9'(pwm_pkg::FILTER_MULT * pwm_pkg::FILTER_BASE))
    else $error("filter not restarted on a code change");

  filter_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && tick && s.sync_code == s.cand && s.timer != 9'h000 |=> s.timer == $past(s.timer) - 9'h001)
    else $error("filter timer did not count down");

  timer_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && !tick |=> $stable(s.timer) && $stable(s.cand))
    else $error("filter moved without a tick");

  pend_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && s.timer != 9'h000 |=> $stable(s.active))
    else $error("code applied while filter running");

  switch_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && period_end && pending |=> s.cnt == 14'h0000 && s.active == $past(s.cand))
    else $error("settled code not applied at period end");

  rest_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && s.high >= ratio && !s.active[3] |=> pwm_o)
    else $error("output not resting high at full duty");

  high_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN |-> s.high <= ratio)
    else $error("high time longer than the period");

  sat_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (VARIANT == pwm_pkg::VAR_FULL || VARIANT == pwm_pkg::VAR_MAX_ONLY) && s.duty <= pwm_pkg::SET_LOW |-> duty_frac == 11'h000)
    else $error("low setting not saturated");

  sat_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (VARIANT == pwm_pkg::VAR_FULL || VARIANT == pwm_pkg::VAR_MIN_ONLY) && s.duty >= pwm_pkg::SET_HIGH |-> duty_frac == pwm_pkg::DUTY_FULL)
    else $error("high setting not saturated");

  linear_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.duty == 10'h258 |-> duty_frac == 11'h26e)
    else $error("mid-range duty off the line");

  pol_plain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s.phase == pwm_pkg::PH_RUN && !s.active[3] |=> pwm_o == $past(raw))
    else $error("plain output wrong");

endmodule
